// *** hdl/asr_params.svh ***
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// angle and status byte addresses
`define ASR_ADDR_ANGLE_HI 7'h03
`define ASR_ADDR_ANGLE_LO 7'h04
`define ASR_ADDR_SPEED 7'h05

// field positions
`define ASR_WEAK_BIT 1
`define ASR_PARITY_BIT 0
`define ASR_OVERSPEED_BIT 3
`define ASR_ANGLE_BITS 14

// nonvolatile configuration window
`define ASR_CFG_BASE 7'h08
`define ASR_CFG_DEPTH 8
`define ASR_CFG_RESET 8'h00
`define ASR_CFG_WIRE_BIT 0

// serial frame layout
`define ASR_BYTE_LAST 3'h7
`define ASR_NSYNC 5

`endif

// *** hdl/asr_pkg.sv ***
package asr_pkg;

  // sensor core sample frozen for one frame
  typedef struct packed {
    logic [13:0] angle;
    logic weak_field;
    logic overspeed;
  } asr_sample_type;

  // configuration fields decoded from the nonvolatile store
  typedef struct packed {
    logic wire_mode;
    logic [11:0] zero_position;
    logic [9:0] abz_resolution;
    logic [2:0] index_width;
    logic [3:0] pole_pairs;
    logic pwm_slow;
  } asr_cfg_type;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_CMD = 2'b01,
    ASR_DATA = 2'b10
  } asr_state_type;

endpackage

// *** hdl/asr_spi_readout.sv ***
`timescale 1ns/1ps
`include "asr_params.svh"
module asr_spi_readout (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sensor core, same clock domain
  input wire asr_pkg::asr_sample_type sample,
  // serial pins
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe,
  input wire logic shared_serial_line_in,
  output logic shared_serial_line_out,
  output logic shared_serial_line_oe,
  // programming supply present
  input wire logic program_voltage_pin,
  // decoded nonvolatile configuration
  output asr_pkg::asr_cfg_type cfg
);
  import asr_pkg::*;

  function automatic logic even_parity(input logic [14:0] bits);
    even_parity = ^bits;
  endfunction

  function automatic logic in_cfg(input logic [6:0] addr);
    in_cfg = (addr >= `ASR_CFG_BASE) &&
             (addr < (`ASR_CFG_BASE + 7'(`ASR_CFG_DEPTH)));
  endfunction

  function automatic logic [2:0] cfg_index(input logic [6:0] addr);
    logic [6:0] diff;
    diff = addr - `ASR_CFG_BASE;
    cfg_index = diff[2:0];
  endfunction

  logic [`ASR_NSYNC-1:0] raw_pins;
  logic [`ASR_NSYNC-1:0] pins_s;
  logic sck_s, sel_n_s, mosi_s, line_s, hv_s;
  logic sck_prev_q, sel_n_prev_q;
  logic sck_rise, sck_fall, frame_start;
  logic in_bit;
  asr_state_type state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic read_q;
  logic [6:0] addr_q;
  logic [7:0] tx_q;
  logic out_q;
  logic drive_q;
  asr_sample_type snap_q;
  logic [7:0] cfg_q [0:`ASR_CFG_DEPTH-1];
  logic byte_done;
  logic [7:0] byte_in;
  logic [6:0] cmd_addr;
  logic [6:0] next_addr;

  assign raw_pins = {program_voltage_pin, shared_serial_line_in, mosi,
                     chip_select_n, sck};

  asr_sync #(
    .WIDTH(`ASR_NSYNC)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(raw_pins),
    .sync_out(pins_s)
  );

  assign sck_s = pins_s[0];
  assign sel_n_s = pins_s[1];
  assign mosi_s = pins_s[2];
  assign line_s = pins_s[3];
  assign hv_s = pins_s[4];

  // edge finding on the synchronised link clock
  always_ff @(posedge clock) begin
    if (rst) begin
      sck_prev_q <= 1'b1;
      sel_n_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      sel_n_prev_q <= sel_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_q & ~sel_n_s;
  assign sck_fall = ~sck_s & sck_prev_q & ~sel_n_s;
  assign frame_start = ~sel_n_s & sel_n_prev_q;
  assign in_bit = cfg.wire_mode ? line_s : mosi_s;
  assign byte_done = sck_rise && (bit_cnt_q == `ASR_BYTE_LAST);
  assign byte_in = {shift_q, in_bit};
  assign cmd_addr = byte_in[6:0];
  assign next_addr = addr_q + 7'h01;

  // register read map; the sample is frozen so a burst is coherent
  function automatic logic [7:0] read_byte(input logic [6:0] addr,
                                           input asr_sample_type s);
    read_byte = 8'h00;
    if (addr == `ASR_ADDR_ANGLE_HI) begin
      read_byte = s.angle[13:6];
    end else if (addr == `ASR_ADDR_ANGLE_LO) begin
      read_byte = {s.angle[5:0], 2'b00};
      read_byte[`ASR_WEAK_BIT] = s.weak_field;
      read_byte[`ASR_PARITY_BIT] =
        even_parity({s.angle, s.weak_field});
    end else if (addr == `ASR_ADDR_SPEED) begin
      read_byte[`ASR_OVERSPEED_BIT] = s.overspeed;
    end else if (in_cfg(addr)) begin
      read_byte = cfg_q[cfg_index(addr)];
    end
  endfunction

  // snapshot at select fall so the three bytes belong together
  always_ff @(posedge clock) begin
    if (rst) begin
      snap_q <= '0;
    end else if (frame_start) begin
      snap_q <= sample;
    end
  end

  // frame sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ASR_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      read_q <= 1'b0;
      addr_q <= 7'h00;
    end else if (sel_n_s) begin
      state_q <= ASR_IDLE;
      bit_cnt_q <= 3'h0;
    end else begin
      if (frame_start) begin
        state_q <= ASR_CMD;
        bit_cnt_q <= 3'h0;
      end
      if (sck_rise) begin
        shift_q <= byte_in[6:0];
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      unique case (state_q)
        ASR_IDLE: begin
        end
        ASR_CMD: begin
          if (byte_done) begin
            read_q <= byte_in[7];
            addr_q <= cmd_addr;
            state_q <= ASR_DATA;
          end
        end
        ASR_DATA: begin
          if (byte_done) begin
            addr_q <= next_addr;
          end
        end
        default: begin
          state_q <= ASR_IDLE;
        end
      endcase
    end
  end

  // transmit path: load on the byte's last rising edge, shift on falls
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_q <= 8'h00;
      out_q <= 1'b0;
    end else if (sel_n_s) begin
      tx_q <= 8'h00;
      out_q <= 1'b0;
    end else if (byte_done && state_q == ASR_CMD) begin
      tx_q <= read_byte(cmd_addr, snap_q);
    end else if (byte_done && state_q == ASR_DATA) begin
      tx_q <= read_byte(next_addr, snap_q);
    end else if (sck_fall && state_q == ASR_DATA && read_q) begin
      out_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // drive only after the first data fall, so a 3-wire host has let go
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_q <= 1'b0;
    end else if (sel_n_s) begin
      drive_q <= 1'b0;
    end else if (sck_fall && state_q == ASR_DATA && read_q) begin
      drive_q <= 1'b1;
    end
  end

  assign miso_out = out_q;
  assign miso_oe = drive_q & ~cfg.wire_mode;
  assign shared_serial_line_out = out_q;
  assign shared_serial_line_oe = drive_q & cfg.wire_mode;

  // nonvolatile store; writes need the programming supply present
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `ASR_CFG_DEPTH; i++) begin
        cfg_q[i] <= `ASR_CFG_RESET;
      end
    end else if (byte_done && state_q == ASR_DATA && !read_q &&
                 hv_s && in_cfg(addr_q)) begin
      cfg_q[cfg_index(addr_q)] <= byte_in;
    end
  end

  assign cfg.wire_mode = cfg_q[0][`ASR_CFG_WIRE_BIT];
  assign cfg.zero_position = {cfg_q[1][3:0], cfg_q[2]};
  assign cfg.abz_resolution = {cfg_q[3][1:0], cfg_q[4]};
  assign cfg.index_width = cfg_q[5][2:0];
  assign cfg.pole_pairs = cfg_q[6][3:0];
  assign cfg.pwm_slow = cfg_q[6][4];

endmodule // asr_spi_readout

// *** hdl/asr_sync.sv ***
`timescale 1ns/1ps
module asr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // levels from outside the clock domain
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // pins idle high so the reset value matches an idle bus
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // asr_sync

// *** testbench/asr_checker.sv ***
`timescale 1ns/1ps
module asr_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial pins
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic program_voltage_pin,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic shared_serial_line_oe,
  // configuration
  input wire asr_pkg::asr_cfg_type cfg
);
  import asr_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_reset;
    @(posedge clock) disable iff (1'b0)
    rst |=> !miso_oe && !shared_serial_line_oe && cfg == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not idle after reset");
  property p_miso_mode;
    miso_oe |-> !cfg.wire_mode && !$past(chip_select_n, 3);
  endproperty
  a_miso_mode: assert property (p_miso_mode)
    else $error("data out driven in 3-wire mode");
  property p_shared_mode;
    shared_serial_line_oe |-> cfg.wire_mode && !$past(chip_select_n, 3);
  endproperty
  a_shared_mode: assert property (p_shared_mode)
    else $error("shared line driven in 4-wire mode");
  // sync delay means the pin has been low two clocks before a change
  property p_out_at_fall;
    $changed(miso_out) && miso_oe && $past(miso_oe) |-> !$past(sck, 2);
  endproperty
  a_out_at_fall: assert property (p_out_at_fall)
    else $error("data out moved outside clock low phase");
  property p_oe_rise;
    $rose(miso_oe) |-> !chip_select_n && !$past(sck, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data out enabled outside a data bit");
  property p_oe_drop;
    $rose(chip_select_n) |-> ##6 (!miso_oe && !shared_serial_line_oe);
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("line still driven after frame end");
  property p_cfg_volt;
    $changed(cfg) |-> $past(program_voltage_pin, 3) && !chip_select_n;
  endproperty
  a_cfg_volt: assert property (p_cfg_volt)
    else $error("config changed without supply or frame");
  property p_cfg_rise;
    $changed(cfg) |-> $past(sck) && $past(sck, 2);
  endproperty
  a_cfg_rise: assert property (p_cfg_rise)
    else $error("config changed away from a rising clock");
  c_read: cover property ($rose(miso_oe));
  c_three: cover property ($rose(shared_serial_line_oe));
  c_cfg: cover property ($changed(cfg));
endmodule // asr_checker
bind asr_spi_readout asr_checker asr_checker_inst (.clock, .rst, .sck,
  .chip_select_n, .program_voltage_pin, .miso_out, .miso_oe,
  .shared_serial_line_oe, .cfg);

// *** testbench/asr_host_model.sv ***
`timescale 1ns/1ps
module asr_host_model (
  // timing
  input wire logic clock,
  // serial pins
  output logic sck,
  output logic chip_select_n,
  output logic mosi,
  output logic host_oe,
  output logic host_d,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic line
);
  initial begin
    sck = 1;
    chip_select_n = 1;
    mosi = 0;
    host_oe = 0;
    host_d = 1;
  end
  // half of a 320 ns link period
  task automatic half();
    repeat (4) @(negedge clock);
  endtask
  // nb below 16 aborts the frame early
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
    input int nb, input logic w3, output logic [23:0] rd);
    logic [31:0] tx;
    tx = {cmd, {3{wd}}};
    rd = '0;
    chip_select_n = 0;
    host_oe = w3;
    for (int i = 0; i < nb; i++) begin
      half();
      sck = 0;
      mosi = tx[31-i];
      host_d = tx[31-i];
      if (i == 8 && cmd[7]) host_oe = 0;
      half();
      sck = 1;
      if (i >= 8) rd = {rd[22:0], w3 ? line : (miso_oe ? miso_out : 1'b1)};
    end
    half();
    chip_select_n = 1;
    mosi = ~mosi;
    host_oe = 0;
    half();
    half();
  endtask
endmodule // asr_host_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import asr_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic pvp = 0;
  asr_sample_type sample = '0;
  logic sck, sel_n, mosi, h_oe, h_d, m_out, m_oe, s_out, s_oe, line;
  asr_cfg_type cfg;
  logic [23:0] rd;
  int error_cnt = 0;
  int n_compared = 0;
  // sample {angle, weak, overspeed} beside the expected burst bytes
  logic [39:0] rows [5] = '{40'h0000_000000, 40'hFFFF_FFFF08,
    40'hAAA8_AAA900, 40'h0006_000600, 40'h8001_800108};
  always #20 clock = ~clock;
  // pull-up on the shared line when nobody drives it
  assign line = s_oe ? s_out : (h_oe ? h_d : 1'b1);
  asr_spi_readout asr_spi_readout_inst (.clock, .rst, .sample, .sck,
    .chip_select_n(sel_n), .mosi, .miso_out(m_out), .miso_oe(m_oe),
    .shared_serial_line_in(line), .shared_serial_line_out(s_out),
    .shared_serial_line_oe(s_oe), .program_voltage_pin(pvp), .cfg);
  asr_host_model asr_host_model_inst (.clock, .sck, .chip_select_n(sel_n),
    .mosi, .host_oe(h_oe), .host_d(h_d), .miso_out(m_out),
    .miso_oe(m_oe), .line);
  task automatic x(input logic [7:0] c, input logic [7:0] w,
    input int n, input logic w3);
    asr_host_model_inst.xfer(c, w, n, w3, rd);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
    $display("test %s done", m);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clock);
    rst = 0;
    repeat (3) @(negedge clock);
    foreach (rows[i]) begin
      sample = rows[i][39:24];
      x(8'h83, 8'h00, 32, 0);
      chk(32'(rd[23:16]), 32'(rows[i][23:16]), "hi");
      chk(32'(rd[15:8]), 32'(rows[i][15:8]), "lo");
      chk(32'(rd[3]), 32'(rows[i][3]), "speed");
    end
    x(8'h84, 8'h00, 16, 0);
    chk({8'h00, rd}, 32'h01, "single");
    x(8'h83, 8'h00, 12, 0);
    x(8'h83, 8'h00, 16, 0);
    chk({8'h00, rd}, 32'h80, "abort");
    x(8'h0E, 8'h1F, 16, 0);
    chk({1'b0, cfg}, 32'h0, "no_supply");
    pvp = 1;
    x(8'h0E, 8'h1F, 16, 0);
    chk({1'b0, cfg}, 32'h1F, "write");
    x(8'h8E, 8'h00, 16, 0);
    chk({8'h00, rd}, 32'h1F, "cfg_read");
    x(8'h08, 8'h01, 16, 0);
    chk({1'b0, cfg}, 32'h4000001F, "three_wire_on");
    x(8'h83, 8'h00, 32, 1);
    chk({8'h00, rd & 24'hFFFF08}, 32'h800108, "three_wire_read");
    x(8'h08, 8'h00, 16, 1);
    chk({1'b0, cfg}, 32'h1F, "three_wire_off");
    // mid-run reset must clear the store back to 4-wire
    rst = 1;
    repeat (2) @(negedge clock);
    rst = 0;
    repeat (3) @(negedge clock);
    chk({1'b0, cfg}, 32'h0, "reset");
    x(8'h83, 8'h00, 16, 0);
    chk({8'h00, rd}, 32'h80, "after_reset");
    finish_test();
  end
endmodule // testbench
